// file: core/chf_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two.
`timescale 1ns/1ps
`default_nettype none
module chf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Fill side
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	// Drain side
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wrPtr_reg;
	logic [PW:0] rdPtr_reg;
	wire push = inValid & inReady;
	wire pop = outValid & outReady;
	wire ptrSame = wrPtr_reg[PW-1:0] == rdPtr_reg[PW-1:0];

	assign outValid = wrPtr_reg != rdPtr_reg;
	assign inReady = !(ptrSame && (wrPtr_reg[PW] != rdPtr_reg[PW]));
	assign outData = mem[rdPtr_reg[PW-1:0]];

	always_ff @(posedge core_clk) begin
		if (push)
			mem[wrPtr_reg[PW-1:0]] <= inData;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
		end else begin
			if (push)
				wrPtr_reg <= wrPtr_reg + 1'b1;
			if (pop)
				rdPtr_reg <= rdPtr_reg + 1'b1;
		end
	end
endmodule // chf_fifo
`default_nettype wire

// file: core/chf_pkg.sv
// Constants for the carrier, hop and FIFO register bank.
// Assumes one core clock; the serial pins arrive unsynchronised.
// How it works
// [R1] High-band bit set selects upper range; clear selects range from 240 MHz.
// [R2] One band index step is 10 MHz low range, 20 MHz high range.
// [R3] Band index zero gives the lowest band: 240 or 480 MHz.
// [R4] Carrier kHz follows band, carrier word, offset and hop formula.
// [R5] Nominal carrier word sits in two bytes, resets 0xBB then 0x80.
// [R6] Hop channel register is eight bits, resets zero, multiplies hop step.
// [R7] Hop step counts in units of 10 kHz.
// [R8] Band select resets 0x75; bit 7 reserved read-only, bit 6 sideband.
// [R9] TX almost-full threshold is six bits, reset 0x37.
// [R10] TX almost-empty threshold is six read-write bits 5:0.
// [R11] RX almost-full threshold is six bits, reset 0x37.
// [R12] Writing the data port bursts bytes into TX FIFO, address held.
// [R13] Host ends a TX burst by raising select after last byte.
// [R14] Reading the data port bursts RX FIFO bytes, address held until select high.
// [R15] Offset word is ten-bit two's complement, step 156.25 Hz times range.
// [R16] Offset registers read back the latest frequency-correction result.
// [R17] Synthesizer target recomputed after any frequency register write.
package chf_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int CARRIER_W = 21;

	// Register addresses
	localparam logic [ADDR_W-1:0] ADDR_OFFSET_LO = 7'h73;
	localparam logic [ADDR_W-1:0] ADDR_OFFSET_HI = 7'h74;
	localparam logic [ADDR_W-1:0] ADDR_BAND = 7'h75;
	localparam logic [ADDR_W-1:0] ADDR_CARRIER_HI = 7'h76;
	localparam logic [ADDR_W-1:0] ADDR_CARRIER_LO = 7'h77;
	localparam logic [ADDR_W-1:0] ADDR_HOP_CH = 7'h79;
	localparam logic [ADDR_W-1:0] ADDR_HOP_STEP = 7'h7A;
	localparam logic [ADDR_W-1:0] ADDR_TX_FULL = 7'h7C;
	localparam logic [ADDR_W-1:0] ADDR_TX_EMPTY = 7'h7D;
	localparam logic [ADDR_W-1:0] ADDR_RX_FULL = 7'h7E;
	localparam logic [ADDR_W-1:0] ADDR_FIFO = 7'h7F;

	// Reset values
	localparam logic [6:0] BAND_RST = 7'h75;
	localparam logic [7:0] CARRIER_HI_RST = 8'hBB;
	localparam logic [7:0] CARRIER_LO_RST = 8'h80;
	localparam logic [7:0] HOP_RST = 8'h00;
	localparam logic [5:0] TX_FULL_RST = 6'h37;
	localparam logic [5:0] TX_EMPTY_RST = 6'h04;
	localparam logic [5:0] RX_FULL_RST = 6'h37;
	localparam logic [9:0] OFFSET_RST = 10'h000;
	localparam logic [CARRIER_W-1:0] CARRIER_RST_KHZ = 21'h0DF638;

	// Band and offset register fields
	localparam int SIDEBAND_BIT = 6;
	localparam int HIGH_BAND_BIT = 5;
	localparam int OFFSET_SIGN_BIT = 9;

	// Carrier formula; 10000/64000 reduces to 5/32
	localparam int BAND_BASE = 24;
	localparam int BAND_SCALE_KHZ = 10000;
	localparam int CARRIER_DIV = 64000;
	localparam int FRAC_NUM = 5;
	localparam int FRAC_SHIFT = 5;
	localparam int HOP_UNIT_KHZ = 10;
	localparam int LOW_RANGE_KHZ = 240000;
	localparam int HIGH_RANGE_KHZ = 480000;

	typedef enum logic {
		PH_ADDR = 1'b0,
		PH_DATA = 1'b1
	} chf_phase_t;
endpackage

// file: core/chf_regs.sv
// Carrier, hop and FIFO-threshold registers behind the four-wire port.
// Serial pins are sampled on core_clk; serial clock must stay well slow.
`timescale 1ns/1ps
`default_nettype none
module chf_regs (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Serial register port
	input wire logic serialClk,
	input wire logic serialDataIn,
	input wire logic serialSelectN,
	output logic serialDataOut,
	output logic serialDataOutEn,
	// Frequency correction result
	input wire logic [9:0] afcResult,
	// Synthesizer and control outputs
	output logic sidebandSel,
	output logic highBand,
	output logic [4:0] bandIndex,
	output logic [15:0] carrierWord,
	output logic [9:0] offsetWord,
	output logic [7:0] hopChannel,
	output logic [7:0] hopStep,
	output logic [chf_pkg::CARRIER_W-1:0] carrierKhz,
	output logic carrierUpdate,
	output logic [5:0] txAlmostFullLevel,
	output logic [5:0] txAlmostEmptyLevel,
	output logic [5:0] rxAlmostFullLevel,
	// TX FIFO drain
	output logic [chf_pkg::DATA_W-1:0] txData,
	output logic txValid,
	input wire logic txReady,
	output logic txFifoFull,
	// RX FIFO fill
	input wire logic [chf_pkg::DATA_W-1:0] rxData,
	input wire logic rxValid,
	output logic rxReady
);
	import chf_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic clkS1, clkS2, clkS3, dinS1, dinS2, selS1, selS2;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			{clkS1, clkS2, clkS3} <= 3'h0;
			{dinS1, dinS2} <= 2'h0;
			{selS1, selS2} <= 2'h3;
		end else begin
			{clkS1, clkS2, clkS3} <= {serialClk, clkS1, clkS2};
			{dinS1, dinS2} <= {serialDataIn, dinS1};
			{selS1, selS2} <= {serialSelectN, selS1};
		end
	end

	////////////////////////////////////////////////////////////////////
	// Serial frame engine
	chf_phase_t phase_reg;
	logic [2:0] bitCnt_reg;
	logic [7:0] shiftIn_reg;
	logic [7:0] outShift_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic isWrite_reg;
	logic [7:0] readData;

	wire sclkRise = clkS2 & ~clkS3 & ~selS2;
	wire byteDone = sclkRise && (bitCnt_reg == 3'h7);
	wire [7:0] shiftByte = {shiftIn_reg[6:0], dinS2};
	wire inData = phase_reg == PH_DATA;
	wire addrDone = byteDone && !inData;
	wire [ADDR_W-1:0] nextAddr = (addr_reg == ADDR_FIFO) ?
		addr_reg : addr_reg + 1'b1; // see [R12] see [R14]
	wire [ADDR_W-1:0] rdAddr = inData ? nextAddr : shiftByte[6:0];
	wire loadRead = byteDone && (inData ? !isWrite_reg : !shiftByte[7]);
	wire regWrEn = byteDone && inData && isWrite_reg;
	wire [7:0] wrByte = shiftByte;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase_reg <= PH_ADDR;
			bitCnt_reg <= 3'h0;
			shiftIn_reg <= 8'h00;
			outShift_reg <= 8'h00;
			addr_reg <= '0;
			isWrite_reg <= 1'b0;
		end else if (selS2) begin
			phase_reg <= PH_ADDR; // see [R14]
			bitCnt_reg <= 3'h0;
		end else if (sclkRise) begin
			bitCnt_reg <= bitCnt_reg + 1'b1;
			shiftIn_reg <= shiftByte;
			outShift_reg <= {outShift_reg[6:0], 1'b0};
			if (addrDone) begin
				phase_reg <= PH_DATA;
				isWrite_reg <= shiftByte[7];
				addr_reg <= shiftByte[6:0];
			end else if (byteDone) begin
				addr_reg <= nextAddr;
			end
			if (loadRead)
				outShift_reg <= readData;
		end
	end

	assign serialDataOut = outShift_reg[7];
	assign serialDataOutEn = !selS2 && inData && !isWrite_reg;

	////////////////////////////////////////////////////////////////////
	// Register storage
	logic [6:0] band_reg;
	logic [7:0] carrierHi_reg, carrierLo_reg, hopCh_reg, hopStep_reg;
	logic [9:0] offset_reg;
	logic [5:0] txFull_reg, txEmpty_reg, rxFull_reg;
	wire wrAt = regWrEn;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			band_reg <= BAND_RST; // see [R8]
			carrierHi_reg <= CARRIER_HI_RST; // see [R5]
			carrierLo_reg <= CARRIER_LO_RST; // see [R5]
			hopCh_reg <= HOP_RST; // see [R6]
			hopStep_reg <= HOP_RST;
			offset_reg <= OFFSET_RST;
			txFull_reg <= TX_FULL_RST; // see [R9]
			txEmpty_reg <= TX_EMPTY_RST;
			rxFull_reg <= RX_FULL_RST; // see [R11]
		end else if (wrAt) begin
			unique case (addr_reg)
			ADDR_OFFSET_LO: offset_reg[7:0] <= wrByte;
			ADDR_OFFSET_HI: offset_reg[9:8] <= wrByte[1:0]; // see [R15]
			ADDR_BAND: band_reg <= wrByte[6:0]; // see [R8]
			ADDR_CARRIER_HI: carrierHi_reg <= wrByte;
			ADDR_CARRIER_LO: carrierLo_reg <= wrByte;
			ADDR_HOP_CH: hopCh_reg <= wrByte;
			ADDR_HOP_STEP: hopStep_reg <= wrByte;
			ADDR_TX_FULL: txFull_reg <= wrByte[5:0]; // see [R9]
			ADDR_TX_EMPTY: txEmpty_reg <= wrByte[5:0]; // see [R10]
			ADDR_RX_FULL: rxFull_reg <= wrByte[5:0]; // see [R11]
			default: ;
			endcase
		end
	end

	assign sidebandSel = band_reg[SIDEBAND_BIT];
	assign highBand = band_reg[HIGH_BAND_BIT];
	assign bandIndex = band_reg[4:0];
	assign carrierWord = {carrierHi_reg, carrierLo_reg};
	assign offsetWord = offset_reg;
	assign hopChannel = hopCh_reg;
	assign hopStep = hopStep_reg;
	assign txAlmostFullLevel = txFull_reg;
	assign txAlmostEmptyLevel = txEmpty_reg;
	assign rxAlmostFullLevel = rxFull_reg;

	////////////////////////////////////////////////////////////////////
	// Read-back mux; offset reads show the correction result
	logic [7:0] rxByte;
	logic rxOutValid;
	wire [7:0] rdOffLo = afcResult[7:0]; // see [R16]
	wire [7:0] rdOffHi = {6'h00, afcResult[9:8]}; // see [R16]
	assign readData =
		(rdAddr == ADDR_OFFSET_LO) ? rdOffLo :
		(rdAddr == ADDR_OFFSET_HI) ? rdOffHi :
		(rdAddr == ADDR_BAND) ? {1'b0, band_reg} : // see [R8]
		(rdAddr == ADDR_CARRIER_HI) ? carrierHi_reg :
		(rdAddr == ADDR_CARRIER_LO) ? carrierLo_reg :
		(rdAddr == ADDR_HOP_CH) ? hopCh_reg :
		(rdAddr == ADDR_HOP_STEP) ? hopStep_reg :
		(rdAddr == ADDR_TX_FULL) ? {2'h0, txFull_reg} :
		(rdAddr == ADDR_TX_EMPTY) ? {2'h0, txEmpty_reg} :
		(rdAddr == ADDR_RX_FULL) ? {2'h0, rxFull_reg} :
		(rdAddr == ADDR_FIFO && rxOutValid) ? rxByte : 8'h00;

	////////////////////////////////////////////////////////////////////
	// FIFOs on the data port
	wire txPush = regWrEn && (addr_reg == ADDR_FIFO); // see [R12]
	wire rxPop = loadRead && (rdAddr == ADDR_FIFO); // see [R14]
	logic txInReady;

	chf_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) txFifo (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.inData(wrByte),
		.inValid(txPush),
		.inReady(txInReady),
		.outData(txData),
		.outValid(txValid),
		.outReady(txReady)
	);

	chf_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rxFifo (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.inData(rxData),
		.inValid(rxValid),
		.inReady(rxReady),
		.outData(rxByte),
		.outValid(rxOutValid),
		.outReady(rxPop)
	);

	assign txFifoFull = !txInReady;

	////////////////////////////////////////////////////////////////////
	// Carrier computation
	wire signed [17:0] fcSum = $signed({2'b00, carrierWord}) +
		$signed({{8{offset_reg[OFFSET_SIGN_BIT]}}, offset_reg}); // see [R15]
	wire signed [31:0] rangeMul = highBand ? 32'sd2 : 32'sd1; // see [R1]
	wire signed [31:0] bandTerm = (32'(bandIndex) + BAND_BASE) *
		BAND_SCALE_KHZ * rangeMul; // see [R2] see [R3]
	wire signed [31:0] fracTerm = (32'(fcSum) * FRAC_NUM * rangeMul)
		>>> FRAC_SHIFT; // see [R4]
	wire signed [31:0] hopTerm = 32'(hopCh_reg) * 32'(hopStep_reg) *
		HOP_UNIT_KHZ; // see [R6] see [R7]
	wire signed [31:0] carrierSum = bandTerm + fracTerm + hopTerm;
	wire [CARRIER_W-1:0] carrierCalc = carrierSum[CARRIER_W-1:0];

	wire freqWr = regWrEn && (addr_reg >= ADDR_OFFSET_LO) &&
		(addr_reg <= ADDR_HOP_STEP) && (addr_reg != ADDR_HOP_CH - 1'b1);
	logic updPend_reg, carrierUpd_reg;
	logic [CARRIER_W-1:0] carrierKhz_reg;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			updPend_reg <= 1'b0;
			carrierUpd_reg <= 1'b0;
			carrierKhz_reg <= CARRIER_RST_KHZ;
		end else begin
			updPend_reg <= freqWr; // see [R17]
			carrierUpd_reg <= updPend_reg;
			if (updPend_reg)
				carrierKhz_reg <= carrierCalc; // see [R17]
		end
	end
	assign carrierKhz = carrierKhz_reg;
	assign carrierUpdate = carrierUpd_reg;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	chk_carrier_update: assert property ( // see [R17]
		freqWr |-> ##2 (carrierKhz == carrierCalc) && carrierUpdate)
		else $error("carrier not refreshed after write");
	chk_low_base: assert property ( // see [R1]
		(!highBand && bandIndex == 5'h00 && carrierWord == 16'h0000 &&
		offset_reg == 10'h000 && hopCh_reg == 8'h00) |->
		carrierCalc == LOW_RANGE_KHZ)
		else $error("low range base wrong");
	chk_high_base: assert property ( // see [R3]
		(highBand && bandIndex == 5'h00 && carrierWord == 16'h0000 &&
		offset_reg == 10'h000 && hopStep_reg == 8'h00) |->
		carrierCalc == HIGH_RANGE_KHZ)
		else $error("high range base wrong");
	chk_band_step: assert property ( // see [R2]
		$changed(bandIndex) && $stable(highBand) && $stable(carrierWord) &&
		$stable(offset_reg) && $stable(hopCh_reg) && $stable(hopStep_reg)
		|-> carrierSum - $past(carrierSum) == (32'(bandIndex) -
		32'($past(bandIndex))) * BAND_SCALE_KHZ * rangeMul)
		else $error("band step size wrong");
	chk_hop_term: assert property ( // see [R6] see [R7]
		$changed(hopCh_reg) && $stable(hopStep_reg) && $stable(band_reg) &&
		$stable(carrierWord) && $stable(offset_reg) |->
		carrierSum - $past(carrierSum) == (32'(hopCh_reg) -
		32'($past(hopCh_reg))) * 32'(hopStep_reg) * HOP_UNIT_KHZ)
		else $error("hop step size wrong");
	chk_band_reserved: assert property ( // see [R8]
		loadRead && rdAddr == ADDR_BAND |=> !outShift_reg[7] &&
		outShift_reg[6:0] == $past(band_reg))
		else $error("band read-back wrong");
	chk_fifo_addr_hold: assert property ( // see [R12]
		byteDone && inData && addr_reg == ADDR_FIFO && !selS2
		|=> addr_reg == ADDR_FIFO)
		else $error("fifo address moved in burst");
	chk_tx_push: assert property ( // see [R12]
		regWrEn && addr_reg == ADDR_FIFO && !txFifoFull |=> txValid)
		else $error("tx byte not queued");
	chk_burst_end: assert property ( // see [R14]
		selS2 |=> phase_reg == PH_ADDR && bitCnt_reg == 3'h0)
		else $error("frame not ended by select");
	chk_offset_read: assert property ( // see [R16]
		loadRead && rdAddr == ADDR_OFFSET_LO |=> outShift_reg ==
		$past(afcResult[7:0]))
		else $error("offset read not from correction");
	chk_thresh_write: assert property ( // see [R9]
		regWrEn && addr_reg == ADDR_TX_FULL |=> txAlmostFullLevel ==
		$past(wrByte[5:0]))
		else $error("tx threshold not written");
	chk_empty_thresh: assert property ( // see [R10]
		regWrEn && addr_reg == ADDR_TX_EMPTY |=> txAlmostEmptyLevel ==
		$past(wrByte[5:0]))
		else $error("tx empty threshold not written");
	chk_rx_thresh: assert property ( // see [R11]
		regWrEn && addr_reg == ADDR_RX_FULL |=> rxAlmostFullLevel ==
		$past(wrByte[5:0]))
		else $error("rx threshold not written");
	chk_carrier_word: assert property ( // see [R5]
		regWrEn && addr_reg == ADDR_CARRIER_HI |=> carrierWord[15:8] ==
		$past(wrByte))
		else $error("carrier word not written");
	chk_rx_pop: assert property ( // see [R14]
		rxPop && rxOutValid |=> outShift_reg == $past(rxByte) &&
		addr_reg == ADDR_FIFO)
		else $error("rx byte not loaded");

	cov_tx_burst: cover property (txPush ##[1:300] txPush);
	cov_rx_burst: cover property (rxPop && rxOutValid ##[1:300] rxPop);
	cov_freq_write: cover property (freqWr ##2 carrierUpdate);
	cov_offset_read: cover property (loadRead && rdAddr == ADDR_OFFSET_LO);
endmodule // chf_regs
`default_nettype wire

// file: sim/chf_host.sv
// Host model that drives the four-wire register port.
// Assumes a 4 ns core clock; each serial clock phase lasts six cycles.
`timescale 1ns/1ps
`default_nettype none
module chf_host (
	// Clock
	input wire logic core_clk,
	// Serial pins
	output logic serialClk,
	output logic serialDataIn,
	output logic serialSelectN,
	input wire logic serialDataOut
);
	initial begin
		serialClk = 1'b0;
		serialDataIn = 1'b0;
		serialSelectN = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic start();
		tick(1);
		serialSelectN = 1'b0;
	endtask
	// Bit set while clock low, read bit taken as clock rises
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			serialDataIn = tx[i];
			tick(6);
			rx[i] = serialDataOut;
			serialClk = 1'b1;
			tick(6);
			serialClk = 1'b0;
		end
	endtask
	// Released data line toggles so a stale level is not trusted
	task automatic stop();
		tick(6);
		serialSelectN = 1'b1;
		serialDataIn = ~serialDataIn;
		tick(6);
	endtask
endmodule // chf_host
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the carrier, hop and FIFO register bank.
// Assumes the host model and the bank share core_clk.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import chf_pkg::*;
	logic core_clk, sys_rst, sClk, sDin, sSelN, sDout, sDoutEn;
	logic sidebandSel, highBand, carrierUpdate, txValid, txReady;
	logic txFifoFull, rxValid, rxReady;
	logic [9:0] afcResult, offsetWord;
	logic [4:0] bandIndex;
	logic [15:0] carrierWord;
	logic [7:0] hopChannel, hopStep, txData, rxData;
	logic [CARRIER_W-1:0] carrierKhz;
	logic [5:0] txAf, txAe, rxAf;
	int num_errors = 0;
	int cmp_count = 0;
	int updCnt = 0;
	chf_regs chf_regs_inst (.core_clk(core_clk), .sys_rst(sys_rst),
		.serialClk(sClk), .serialDataIn(sDin), .serialSelectN(sSelN),
		.serialDataOut(sDout), .serialDataOutEn(sDoutEn),
		.afcResult(afcResult), .sidebandSel(sidebandSel),
		.highBand(highBand), .bandIndex(bandIndex),
		.carrierWord(carrierWord), .offsetWord(offsetWord),
		.hopChannel(hopChannel), .hopStep(hopStep),
		.carrierKhz(carrierKhz), .carrierUpdate(carrierUpdate),
		.txAlmostFullLevel(txAf), .txAlmostEmptyLevel(txAe),
		.rxAlmostFullLevel(rxAf), .txData(txData), .txValid(txValid),
		.txReady(txReady), .txFifoFull(txFifoFull), .rxData(rxData),
		.rxValid(rxValid), .rxReady(rxReady));
	chf_host chf_host_inst (.core_clk(core_clk), .serialClk(sClk),
		.serialDataIn(sDin), .serialSelectN(sSelN), .serialDataOut(sDout));
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk) if (carrierUpdate === 1'b1) updCnt++;
	////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s %0h/%0h", $time, m, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (num_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] x;
		chf_host_inst.start();
		chf_host_inst.xfer({1'b1, a[6:0]}, x);
		chf_host_inst.xfer(d, x);
		chf_host_inst.stop();
		tick(8);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] x;
		chf_host_inst.start();
		chf_host_inst.xfer({1'b0, a[6:0]}, x);
		chf_host_inst.xfer(8'h00, x);
		chf_host_inst.stop();
		chk(x, e, "read");
	endtask
	function automatic logic [31:0] khz(input int fb, hb, fc, fo, ch, st);
		return (fb + 24) * 10000 * (hb + 1) + (fc + fo) * 5 * (hb + 1) / 32
			+ ch * st * 10;
	endfunction
	////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [7:0] ra[8] = '{8'h75, 8'h76, 8'h77, 8'h79, 8'h7A, 8'h7C,
			8'h7D, 8'h7E};
		logic [7:0] re[8] = '{8'h75, 8'hBB, 8'h80, 8'h00, 8'h00, 8'h37,
			8'h04, 8'h37};
		chk(carrierKhz, khz(21, 1, 48000, 0, 0, 0), "rst khz");
		chk(carrierWord, 16'hBB80, "rst word");
		for (int i = 0; i < 8; i++)
			rdchk(ra[i], re[i]);
	endtask
	task automatic t_carrier();
		int u;
		u = updCnt;
		wr(8'h76, 8'h00);
		wr(8'h77, 8'h00);
		wr(8'h75, 8'h00);
		chk(carrierWord, 16'h0000, "word");
		chk(carrierKhz, 240000, "low base");
		wr(8'h75, 8'h20);
		chk(carrierKhz, 480000, "high base");
		wr(8'h75, 8'h21);
		chk(carrierKhz, 500000, "high step");
		wr(8'h75, 8'h01);
		chk({highBand, bandIndex}, 6'h01, "band");
		chk(carrierKhz, 250000, "low step");
		wr(8'h79, 8'h03);
		wr(8'h7A, 8'h05);
		chk({hopChannel, hopStep}, 16'h0305, "hop regs");
		chk(carrierKhz, khz(1, 0, 0, 0, 3, 5), "hop");
		wr(8'h74, 8'h03);
		wr(8'h73, 8'hC0);
		chk(offsetWord, 10'h3C0, "offset");
		chk(carrierKhz, khz(1, 0, 0, -64, 3, 5), "neg ofs");
		wr(8'h75, 8'h21);
		chk(carrierKhz, khz(1, 1, 0, -64, 3, 5), "hb ofs");
		chk(updCnt - u, 11, "updates");
		rdchk(8'h73, 8'hA5);
		rdchk(8'h74, 8'h02);
	endtask
	task automatic t_regs();
		wr(8'h75, 8'hFF);
		rdchk(8'h75, 8'h7F);
		chk(sidebandSel, 1, "sideband");
		wr(8'h7C, 8'hFF);
		rdchk(8'h7C, 8'h3F);
		chk(txAf, 6'h3F, "tx af");
		wr(8'h7D, 8'hA5);
		rdchk(8'h7D, 8'h25);
		chk(txAe, 6'h25, "tx ae");
		wr(8'h7E, 8'hC1);
		chk(rxAf, 6'h01, "rx af");
		wr(8'h78, 8'h55);
		rdchk(8'h78, 8'h00);
	endtask
	task automatic t_tx();
		logic [7:0] x;
		chf_host_inst.start();
		chf_host_inst.xfer(8'hFF, x);
		for (int i = 0; i < 17; i++)
			chf_host_inst.xfer(8'h30 + i[7:0], x);
		chf_host_inst.stop();
		chk(txFifoFull, 1, "tx full");
		txReady = 1'b1;
		for (int i = 0; i < 16; i++) begin
			chk({txValid, txData}, {1'b1, 8'h30 + i[7:0]}, "tx");
			tick(1);
		end
		txReady = 1'b0;
		chk(txValid, 0, "tx empty");
	endtask
	task automatic t_rx();
		logic [7:0] x;
		rxValid = 1'b1;
		for (int i = 0; i < 16; i++) begin
			rxData = 8'hA0 + i[7:0];
			tick(1);
		end
		rxValid = 1'b0;
		chk(rxReady, 0, "rx full");
		chf_host_inst.start();
		chf_host_inst.xfer(8'h7F, x);
		chk(sDoutEn, 1, "oe burst");
		for (int i = 0; i < 17; i++) begin
			chf_host_inst.xfer(8'h00, x);
			chk(x, i < 16 ? 8'hA0 + i[7:0] : 8'h00, "rx");
		end
		chf_host_inst.stop();
		chk(sDoutEn, 0, "oe end");
		chk(rxReady, 1, "rx drained");
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		num_errors++;
		report_and_stop();
	end
	initial begin
		sys_rst = 1'b1;
		afcResult = 10'h2A5;
		txReady = 1'b0;
		rxValid = 1'b0;
		rxData = 8'h00;
		tick(5);
		sys_rst = 1'b0;
		tick(4);
		t_reset();
		t_carrier();
		t_regs();
		t_tx();
		t_rx();
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
